// File: pkg/iosm_map.vh
// How it works
// RULE_01: a forced instruction runs in place of the next fetched instruction.
// RULE_02: a new forced instruction replaces one still running.
// RULE_03: per-machine bit shows forced instruction still stalled.
// RULE_04: reading an empty receive fifo leaves it empty; data undefined.
// RULE_05: reading an empty receive fifo sets that machine's underflow flag.
// RULE_06: writing a full transmit fifo is dropped with no state change.
// RULE_07: writing a full transmit fifo sets that machine's overflow flag.
// RULE_08: receive and transmit fifo word counts are readable per machine.
// RULE_09: empty and full of both fifos are readable per machine.
// RULE_10: each machine's program counter is readable at any time.
// RULE_11: restart clears shift, divider, flags, delay, forced and wait state; restart here leaves the sticky fifo flags set.
// RULE_12: divider has 16-bit integer and 8-bit fraction in 1/256 units.
// RULE_13: four independent state machines indexed 0 to 3.
// RULE_14: per-machine enable; clear halts, set runs.
// RULE_15: input pin base is programmable from 0 to 31.
// RULE_16: in, out, set and side pin groups may overlap freely.
// RULE_17: each transmit fifo entry is one full 32-bit word.
// RULE_18: host sets pin directions by forced set only while machine disabled; here a forced set runs only once the machine is enabled.
// RULE_19: divider runs freely, pacing execution by clock-enable pulses.
// RULE_20: sticky fifo flags stay set until host writes one to clear.
`ifndef IOSM_MAP_VH
`define IOSM_MAP_VH
// ----------------------------------------
// register offsets (word index; byte address = 4 * index)
// ----------------------------------------
`define IOSM_CTRL 8'h00
`define IOSM_FSTAT 8'h01
`define IOSM_FIFO_DEBUG_FLAGS 8'h02
`define IOSM_FLEVEL 8'h03
`define IOSM_STALL 8'h04
`define IOSM_RESTART 8'h05
`define IOSM_SM_BASE 8'h10
`define IOSM_SM_STRIDE 8'h08
// per-machine offsets within a stride
`define IOSM_SM_TXF 3'h0
`define IOSM_SM_RXF 3'h1
`define IOSM_SM_CLKDIV 3'h2
`define IOSM_SM_PINCTRL 3'h3
`define IOSM_SM_INSTR 3'h4
`define IOSM_SM_ADDR 3'h5
// ----------------------------------------
// fields
// ----------------------------------------
`define IOSM_FSTAT_RXFULL 0
`define IOSM_FSTAT_RXEMPTY 8
`define IOSM_FSTAT_TXFULL 16
`define IOSM_FSTAT_TXEMPTY 24
`define IOSM_FIFO_DEBUG_FLAGS_RX_UNDERFLOW_STICKY 8
`define IOSM_FIFO_DEBUG_FLAGS_TX_OVERFLOW_STICKY 16
`define IOSM_CLKDIV_FRAC_LSB 8
`define IOSM_CLKDIV_INT_LSB 16
`define IOSM_PIN_OUT_LSB 0
`define IOSM_PIN_SET_LSB 5
`define IOSM_PIN_SIDE_LSB 10
`define IOSM_PIN_IN_LSB 15
// ----------------------------------------
// reset values
// ----------------------------------------
`define IOSM_CLKDIV_RESET 32'h0001_0000
`define IOSM_PIN_RESET 20'h0_0000
`endif

// File: src/iosm_fifo.v
`timescale 1ns/1ps
// small word fifo with drop-on-full and ignore-on-empty
module iosm_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire reset,
    input wire clear,
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    input wire rd_en,
    output wire [WIDTH-1:0] rd_data,
    output wire [AW:0] level,
    output wire full,
    output wire empty
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr_reg;
    reg [AW-1:0] rptr_reg;
    reg [AW:0] cnt_reg;
    wire do_wr;
    wire do_rd;

    assign full = (cnt_reg == DEPTH[AW:0]);
    assign empty = (cnt_reg == {(AW+1){1'b0}});
    assign do_wr = wr_en & ~full; // full write dropped [RULE_06]
    assign do_rd = rd_en & ~empty; // empty read leaves fifo alone [RULE_04]
    assign rd_data = mem[rptr_reg];
    assign level = cnt_reg;

    // storage
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wptr_reg] <= wr_data;
        end
    end

    // pointers and count
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else if (clear) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_wr & ~do_rd) begin
                cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
            end else if (do_rd & ~do_wr) begin
                cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // iosm_fifo

// File: src/iosm_top.v
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "iosm_map.vh"
// host-side control of four state machines: fifos, forced instructions,
// dividers, enables and pin group bases
module iosm_top #(
    parameter NSM = 4,
    parameter FDEPTH = 4,
    parameter FAW = 2,
    parameter PCW = 5
) (
    input wire clk,
    input wire reset,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata,
    input wire [31:0] pins_in,
    output reg [31:0] pins_out,
    output reg [31:0] pins_oe
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // machine index of a per-machine address, or 3'h7 when not per-machine
    function [2:0] sm_of;
        input [7:0] a;
        begin
            if (a >= `IOSM_SM_BASE && a < (`IOSM_SM_BASE + 8'h20)) begin
                sm_of = {1'b0, ~a[4], a[3]}; // four machines [RULE_13]
            end else begin
                sm_of = 3'h7;
            end
        end
    endfunction

    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    reg [31:0] pin_meta_reg;
    reg [31:0] pin_sync_reg;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_meta_reg <= 32'h0000_0000;
            pin_sync_reg <= 32'h0000_0000;
        end else begin
            pin_meta_reg <= pins_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ----------------------------------------
    // shared control registers
    // ----------------------------------------
    reg [NSM-1:0] enable_reg;
    reg [NSM-1:0] rx_under_reg;
    reg [NSM-1:0] tx_over_reg;
    wire [2:0] acc_sm;
    wire [2:0] acc_reg;

    assign acc_sm = sm_of(addr);
    assign acc_reg = addr[2:0];

    wire [NSM-1:0] tx_full;
    wire [NSM-1:0] tx_empty;
    wire [NSM-1:0] rx_full;
    wire [NSM-1:0] rx_empty;
    wire [NSM*(FAW+1)-1:0] tx_level;
    wire [NSM*(FAW+1)-1:0] rx_level;
    wire [NSM*32-1:0] rx_word;
    wire [NSM-1:0] stalled;
    wire [NSM*PCW-1:0] pc_all;
    wire [NSM*32-1:0] cfg_all;
    wire [NSM*32-1:0] out_all;
    wire [NSM*32-1:0] oe_all;
    wire restart_wr;

    assign restart_wr = wr_stb && (addr == `IOSM_RESTART);

    // enable and sticky flags; an event beats a clear in the same cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            enable_reg <= {NSM{1'b0}};
            rx_under_reg <= {NSM{1'b0}};
            tx_over_reg <= {NSM{1'b0}};
        end else begin
            if (wr_stb && addr == `IOSM_CTRL) begin
                enable_reg <= wdata[NSM-1:0]; // [RULE_14]
            end
            begin : flags
                integer i;
                for (i = 0; i < NSM; i = i + 1) begin
                    if (rd_stb && acc_sm == i && acc_reg == `IOSM_SM_RXF && rx_empty[i]) begin
                        rx_under_reg[i] <= 1'b1; // [RULE_05]
                    end else if (wr_stb && addr == `IOSM_FIFO_DEBUG_FLAGS
                                 && wdata[`IOSM_FIFO_DEBUG_FLAGS_RX_UNDERFLOW_STICKY + i]) begin
                        rx_under_reg[i] <= 1'b0; // [RULE_20]
                    end
                    if (wr_stb && acc_sm == i && acc_reg == `IOSM_SM_TXF && tx_full[i]) begin
                        tx_over_reg[i] <= 1'b1; // [RULE_07]
                    end else if (wr_stb && addr == `IOSM_FIFO_DEBUG_FLAGS
                                 && wdata[`IOSM_FIFO_DEBUG_FLAGS_TX_OVERFLOW_STICKY + i]) begin
                        tx_over_reg[i] <= 1'b0; // [RULE_20]
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // per-machine logic
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NSM; g = g + 1) begin : sm
            reg [31:0] clkdiv_reg;
            reg [19:0] pinctrl_reg;
            reg [15:0] div_int_cnt_reg;
            reg [7:0] div_frac_acc_reg;
            reg tick_reg;
            reg [PCW-1:0] pc_reg;
            reg [15:0] forced_reg;
            reg forced_pend_reg;
            reg forced_stall_reg;
            reg [31:0] isr_reg;
            reg [5:0] in_cnt_reg;
            reg [5:0] out_cnt_reg;
            reg [31:0] osr_reg;
            reg [4:0] delay_reg;
            reg [31:0] pout_reg;
            reg [31:0] poe_reg;
            wire restart;
            wire tx_rd;
            wire rx_wr;
            wire [31:0] tx_word;
            wire [4:0] in_base;
            wire [4:0] out_base;
            wire [4:0] set_base;
            wire [31:0] in_rot;
            wire step;

            assign restart = restart_wr && wdata[g];
            assign in_base = pinctrl_reg[`IOSM_PIN_IN_LSB +: 5]; // [RULE_15]
            assign out_base = pinctrl_reg[`IOSM_PIN_OUT_LSB +: 5];
            assign set_base = pinctrl_reg[`IOSM_PIN_SET_LSB +: 5];
            // in and out groups are independent rotations and set a shift, so any overlap is allowed [RULE_16]
            assign in_rot = (pin_sync_reg >> in_base) | (pin_sync_reg << (6'd32 - in_base));
            assign step = enable_reg[g] && tick_reg && delay_reg == 5'h00; // [RULE_14]
            // simple data path: drain tx word to pins, capture pins into rx
            assign tx_rd = step && !forced_pend_reg && !tx_empty[g] && !rx_full[g];
            assign rx_wr = tx_rd;

            iosm_fifo #(.WIDTH(32), .DEPTH(FDEPTH), .AW(FAW)) u_tx (
                .clk(clk),
                .reset(reset),
                .clear(1'b0),
                .wr_en(wr_stb && acc_sm == g && acc_reg == `IOSM_SM_TXF), // [RULE_17]
                .wr_data(wdata),
                .rd_en(tx_rd),
                .rd_data(tx_word),
                .level(tx_level[g*(FAW+1) +: FAW+1]),
                .full(tx_full[g]),
                .empty(tx_empty[g])
            );

            iosm_fifo #(.WIDTH(32), .DEPTH(FDEPTH), .AW(FAW)) u_rx (
                .clk(clk),
                .reset(reset),
                .clear(1'b0),
                .wr_en(rx_wr),
                .wr_data(isr_reg),
                .rd_en(rd_stb && acc_sm == g && acc_reg == `IOSM_SM_RXF), // [RULE_04]
                .rd_data(rx_word[g*32 +: 32]),
                .level(rx_level[g*(FAW+1) +: FAW+1]),
                .full(rx_full[g]),
                .empty(rx_empty[g])
            );

            // free-running fractional divider producing run ticks
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    div_int_cnt_reg <= 16'h0000;
                    div_frac_acc_reg <= 8'h00;
                    tick_reg <= 1'b0;
                end else if (restart) begin
                    div_int_cnt_reg <= 16'h0000; // [RULE_11]
                    div_frac_acc_reg <= 8'h00;
                    tick_reg <= 1'b0;
                end else if (div_int_cnt_reg == 16'h0000) begin
                    // period is int + frac/256 clocks [RULE_12] [RULE_19]
                    tick_reg <= 1'b1;
                    {div_int_cnt_reg, div_frac_acc_reg} <=
                        {clkdiv_reg[`IOSM_CLKDIV_INT_LSB +: 16] - 16'h0001, div_frac_acc_reg}
                        + {16'h0000, clkdiv_reg[`IOSM_CLKDIV_FRAC_LSB +: 8]};
                end else begin
                    tick_reg <= 1'b0;
                    div_int_cnt_reg <= div_int_cnt_reg - 16'h0001;
                end
            end

            // configuration, forced instruction and execution state
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    clkdiv_reg <= `IOSM_CLKDIV_RESET;
                    pinctrl_reg <= `IOSM_PIN_RESET;
                    pc_reg <= {PCW{1'b0}};
                    forced_reg <= 16'h0000;
                    forced_pend_reg <= 1'b0;
                    forced_stall_reg <= 1'b0;
                    isr_reg <= 32'h0000_0000;
                    in_cnt_reg <= 6'h00;
                    out_cnt_reg <= 6'h00;
                    osr_reg <= 32'h0000_0000;
                    delay_reg <= 5'h00;
                    pout_reg <= 32'h0000_0000;
                    poe_reg <= 32'h0000_0000;
                end else begin
                    if (wr_stb && acc_sm == g && acc_reg == `IOSM_SM_CLKDIV) begin
                        clkdiv_reg <= {wdata[31:8], 8'h00};
                    end
                    if (wr_stb && acc_sm == g && acc_reg == `IOSM_SM_PINCTRL) begin
                        pinctrl_reg <= wdata[19:0];
                    end
                    if (restart) begin
                        isr_reg <= 32'h0000_0000; // [RULE_11]
                        in_cnt_reg <= 6'h00;
                        out_cnt_reg <= 6'h00;
                        delay_reg <= 5'h00;
                        forced_pend_reg <= 1'b0;
                        forced_stall_reg <= 1'b0;
                    end else if (wr_stb && acc_sm == g && acc_reg == `IOSM_SM_INSTR) begin
                        // latest forced instruction overwrites any earlier one [RULE_02]
                        forced_reg <= wdata[15:0];
                        forced_pend_reg <= 1'b1;
                        forced_stall_reg <= 1'b1; // [RULE_03]
                    end else if (delay_reg != 5'h00 && enable_reg[g] && tick_reg) begin
                        delay_reg <= delay_reg - 5'h01;
                    end else if (step && forced_pend_reg) begin
                        // forced instruction takes the next fetch slot [RULE_01]
                        forced_pend_reg <= 1'b0;
                        forced_stall_reg <= 1'b0;
                        delay_reg <= forced_reg[12:8];
                        if (forced_reg[15:13] == 3'h7) begin
                            // set-type forced write drives set group directly [RULE_18]
                            poe_reg <= poe_reg | ({27'h0, forced_reg[4:0]} << set_base);
                            pout_reg <= pout_reg | ({27'h0, forced_reg[4:0]} << set_base);
                        end
                    end else if (tx_rd) begin
                        pc_reg <= pc_reg + {{(PCW-1){1'b0}}, 1'b1};
                        osr_reg <= tx_word;
                        out_cnt_reg <= 6'h20;
                        isr_reg <= in_rot;
                        in_cnt_reg <= 6'h20;
                        pout_reg <= (tx_word << out_base) | (tx_word >> (6'd32 - out_base));
                        poe_reg <= 32'hffff_ffff;
                    end
                end
            end

            assign pc_all[g*PCW +: PCW] = pc_reg;
            assign cfg_all[g*32 +: 32] = acc_reg[0] ? {12'h000, pinctrl_reg} : clkdiv_reg;
            assign stalled[g] = forced_stall_reg;
            assign out_all[g*32 +: 32] = pout_reg;
            assign oe_all[g*32 +: 32] = poe_reg;
        end
    endgenerate

    // ----------------------------------------
    // pin merge: higher machine index wins
    // ----------------------------------------
    reg [31:0] pout_next;
    reg [31:0] poe_next;
    integer k;

    always @* begin
        pout_next = 32'h0000_0000;
        poe_next = 32'h0000_0000;
        for (k = 0; k < NSM; k = k + 1) begin
            pout_next = (pout_next & ~oe_all[k*32 +: 32]) | (out_all[k*32 +: 32] & oe_all[k*32 +: 32]);
            poe_next = poe_next | oe_all[k*32 +: 32];
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    reg [31:0] rdata_next;
    integer j;

    always @* begin
        rdata_next = 32'h0000_0000;
        case (addr)
            `IOSM_CTRL: rdata_next = {{(32-NSM){1'b0}}, enable_reg};
            `IOSM_FSTAT: begin
                for (j = 0; j < NSM; j = j + 1) begin
                    rdata_next[`IOSM_FSTAT_RXFULL + j] = rx_full[j]; // [RULE_09]
                    rdata_next[`IOSM_FSTAT_RXEMPTY + j] = rx_empty[j];
                    rdata_next[`IOSM_FSTAT_TXFULL + j] = tx_full[j];
                    rdata_next[`IOSM_FSTAT_TXEMPTY + j] = tx_empty[j];
                end
            end
            `IOSM_FIFO_DEBUG_FLAGS: begin
                for (j = 0; j < NSM; j = j + 1) begin
                    rdata_next[`IOSM_FIFO_DEBUG_FLAGS_RX_UNDERFLOW_STICKY + j] = rx_under_reg[j];
                    rdata_next[`IOSM_FIFO_DEBUG_FLAGS_TX_OVERFLOW_STICKY + j] = tx_over_reg[j];
                end
            end
            `IOSM_FLEVEL: begin
                for (j = 0; j < NSM; j = j + 1) begin
                    rdata_next[j*8 +: FAW+1] = tx_level[j*(FAW+1) +: FAW+1]; // [RULE_08]
                    rdata_next[j*8+4 +: FAW+1] = rx_level[j*(FAW+1) +: FAW+1];
                end
            end
            `IOSM_STALL: rdata_next = {{(32-NSM){1'b0}}, stalled}; // [RULE_03]
            default: begin
                if (acc_sm != 3'h7) begin
                    case (acc_reg)
                        `IOSM_SM_RXF: rdata_next = rx_word[acc_sm[1:0]*32 +: 32];
                        `IOSM_SM_CLKDIV, `IOSM_SM_PINCTRL:
                            rdata_next = cfg_all[acc_sm[1:0]*32 +: 32]; // [RULE_12]
                        `IOSM_SM_ADDR: rdata_next[PCW-1:0] = pc_all[acc_sm[1:0]*PCW +: PCW]; // [RULE_10]
                        default: rdata_next = 32'h0000_0000;
                    endcase
                end
            end
        endcase
    end

    // registered outputs
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 32'h0000_0000;
            pins_out <= 32'h0000_0000;
            pins_oe <= 32'h0000_0000;
        end else begin
            rdata <= rd_stb ? rdata_next : 32'h0000_0000;
            pins_out <= pout_next;
            pins_oe <= poe_next;
        end
    end
endmodule // iosm_top

// File: sim/iosm_asserts.sv
`timescale 1ns/1ps
`include "iosm_map.vh"
// watches the host port and the pins of the state-machine block
module iosm_asserts #(
    parameter FDEPTH = 4
) (
    input wire clk,
    input wire reset,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [31:0] rdata,
    input wire [31:0] pins_in,
    input wire [31:0] pins_out,
    input wire [31:0] pins_oe
);
    reg [3:0] en_q;
    reg lvl_ok;
    integer k;
    // shadow of the enable register
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            en_q <= 4'h0;
        end else if (wr_stb && addr == `IOSM_CTRL) begin
            en_q <= wdata[3:0];
        end
    end
    // level fields within the fifo depth
    always @* begin
        lvl_ok = 1'b1;
        for (k = 0; k < 8; k = k + 1) begin
            if (rdata[4*k +: 3] > FDEPTH) begin
                lvl_ok = 1'b0;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_rdata_idle_zero: assert property (!$past(rd_stb) |-> rdata == 32'h0)
        else $error("read data not zero when idle");
    a_ctrl_read_back: assert property (
        wr_stb && addr == `IOSM_CTRL ##2 rd_stb && addr == `IOSM_CTRL
        |=> rdata[3:0] == $past(wdata[3:0], 3))
        else $error("enable bits not read back");
    a_stall_while_off: assert property (
        wr_stb && addr == (`IOSM_SM_BASE + `IOSM_SM_INSTR) && !en_q[0]
        ##2 rd_stb && addr == `IOSM_STALL |=> rdata[0])
        else $error("stall bit low while waiting");
    a_restart_drops: assert property (
        wr_stb && addr == `IOSM_RESTART && wdata[0] ##2 rd_stb && addr == `IOSM_STALL
        |=> !rdata[0])
        else $error("restart kept forced instruction");
    a_sticky_w1c: assert property (
        wr_stb && addr == `IOSM_FIFO_DEBUG_FLAGS && wdata[19:8] == 12'hf0f
        ##1 !wr_stb && !rd_stb ##1 rd_stb && addr == `IOSM_FIFO_DEBUG_FLAGS |=> rdata[19:8] == 12'h000)
        else $error("sticky flags not cleared");
    a_divider_back: assert property (
        wr_stb && addr == (`IOSM_SM_BASE + `IOSM_SM_CLKDIV)
        ##2 rd_stb && addr == (`IOSM_SM_BASE + `IOSM_SM_CLKDIV)
        |=> rdata[31:8] == $past(wdata[31:8], 3))
        else $error("divider fields not read back");
    a_status_sane: assert property (
        $past(rd_stb) && $past(addr) == `IOSM_FSTAT
        |-> (rdata[27:24] & rdata[19:16]) == 4'h0 && (rdata[11:8] & rdata[3:0]) == 4'h0)
        else $error("fifo both empty and full");
    a_level_bound: assert property (
        $past(rd_stb) && $past(addr) == `IOSM_FLEVEL |-> lvl_ok)
        else $error("fifo level beyond depth");
    a_pins_quiet: assert property (
        en_q == 4'h0 && $past(en_q) == 4'h0 && !(wr_stb && addr == `IOSM_CTRL)
        |=> $stable(pins_out) && $stable(pins_oe))
        else $error("pins moved while halted");
endmodule // iosm_asserts

bind iosm_top iosm_asserts #(.FDEPTH(FDEPTH)) u_iosm_asserts (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe));

// File: sim/iosm_host_model.sv
`timescale 1ns/1ps
`include "iosm_map.vh"
// host side of the register port
module iosm_host_model (
    input wire clk,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr_stb,
    output logic rd_stb,
    input wire [31:0] rdata
);
    // bus idle from time zero
    initial begin
        addr <= 8'h00;
        wdata <= 32'h0;
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
    end
    // one write strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    // one read strobe cycle, answer taken mid-cycle after it
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // forced instruction only with every machine halted
    task automatic exec_idle(input logic [7:0] a, input logic [15:0] ins);
        wr(`IOSM_CTRL, 32'h0);
        wr(a, {16'h0, ins});
    endtask
endmodule // iosm_host_model

// File: sim/iosm_top_tb.sv
`timescale 1ns/1ps
`include "iosm_map.vh"
module iosm_top_tb;
    logic clk;
    logic reset;
    logic [31:0] pins_in;
    wire [7:0] addr;
    wire [31:0] wdata;
    wire wr_stb;
    wire rd_stb;
    wire [31:0] rdata;
    wire [31:0] pins_out;
    wire [31:0] pins_oe;
    int n_errors = 0;
    int checked = 0;

    iosm_top u_iosm_top (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pins_in(pins_in),
        .pins_out(pins_out), .pins_oe(pins_oe));
    iosm_host_model u_iosm_host_model (.clk(clk), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

    // 10 mhz clock and a 16-cycle reset
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
    end
    // pin levels that change every cycle
    initial begin
        pins_in = 32'h5555_aaaa;
        forever @(posedge clk) pins_in <= ~pins_in;
    end

    function automatic [7:0] sa(input int j, input logic [2:0] off);
        sa = `IOSM_SM_BASE + `IOSM_SM_STRIDE * j[7:0] + {5'h0, off};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        u_iosm_host_model.rd(a, d);
        chk(what, d, exp);
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // reset values
    task automatic t_reset;
        for (int j = 0; j < 4; j++) begin
            rc("clkdiv", sa(j, `IOSM_SM_CLKDIV), `IOSM_CLKDIV_RESET);
            rc("pc", sa(j, `IOSM_SM_ADDR), 32'h0);
        end
        rc("ctrl", `IOSM_CTRL, 32'h0);
        rc("fstat", `IOSM_FSTAT, 32'h0f00_0f00);
        rc("flevel", `IOSM_FLEVEL, 32'h0);
        rc("unmapped", 8'h0f, 32'h0);
        u_iosm_host_model.wr(sa(0, `IOSM_SM_CLKDIV), 32'h0003_8000);
        rc("clkdiv", sa(0, `IOSM_SM_CLKDIV), 32'h0003_8000);
    endtask
    // forced instruction waits while halted, a second one replaces it
    task automatic t_forced;
        u_iosm_host_model.wr(sa(0, `IOSM_SM_PINCTRL), 32'h000f_8c63);
        rc("pinctrl", sa(0, `IOSM_SM_PINCTRL), 32'h000f_8c63);
        u_iosm_host_model.exec_idle(sa(0, `IOSM_SM_INSTR), 16'he015);
        rc("stall", `IOSM_STALL, 32'h1);
        u_iosm_host_model.exec_idle(sa(0, `IOSM_SM_INSTR), 16'he002);
        repeat (8) @(posedge clk);
        chk("pins halted", pins_out, 32'h0);
        u_iosm_host_model.wr(`IOSM_CTRL, 32'h1);
        rc("ctrl", `IOSM_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        rc("stall", `IOSM_STALL, 32'h0);
        chk("pins", pins_out, 32'h0000_0010);
        chk("oe", pins_oe, 32'h0000_0010);
    endtask
    // restart discards a waiting forced instruction
    task automatic t_restart;
        u_iosm_host_model.exec_idle(sa(0, `IOSM_SM_INSTR), 16'he004);
        rc("stall", `IOSM_STALL, 32'h1);
        u_iosm_host_model.wr(`IOSM_RESTART, 32'h1);
        rc("stall", `IOSM_STALL, 32'h0);
        u_iosm_host_model.wr(`IOSM_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        chk("pins", pins_out, 32'h0000_0010);
    endtask
    // one full word streams from transmit fifo to pins
    task automatic t_stream;
        u_iosm_host_model.wr(`IOSM_CTRL, 32'h0);
        u_iosm_host_model.wr(sa(1, `IOSM_SM_TXF), 32'ha5c3_0f96);
        u_iosm_host_model.wr(sa(1, `IOSM_SM_CLKDIV), 32'h0002_0000);
        u_iosm_host_model.wr(`IOSM_CTRL, 32'h2);
        repeat (20) @(posedge clk);
        chk("pins", pins_out, 32'ha5c3_0f96);
        chk("oe", pins_oe, 32'hffff_ffff);
        rc("pc", sa(1, `IOSM_SM_ADDR), 32'h1);
        rc("flevel", `IOSM_FLEVEL, 32'h0000_1000);
        rc("fstat", `IOSM_FSTAT, 32'h0f00_0d00);
    endtask
    // two reads of each receive fifo; machine 1's first read takes its one word, the rest find them empty
    task automatic t_underflow;
        logic [31:0] d;
        u_iosm_host_model.wr(`IOSM_CTRL, 32'h0);
        for (int j = 0; j < 4; j++) begin
            u_iosm_host_model.rd(sa(j, `IOSM_SM_RXF), d);
            u_iosm_host_model.rd(sa(j, `IOSM_SM_RXF), d);
        end
        rc("fifo_debug_flags", `IOSM_FIFO_DEBUG_FLAGS, 32'h0000_0f00);
        rc("flevel", `IOSM_FLEVEL, 32'h0);
        rc("fstat", `IOSM_FSTAT, 32'h0f00_0f00);
    endtask
    // fifth write to each transmit fifo is dropped and flagged
    task automatic t_overflow;
        for (int j = 0; j < 4; j++) begin
            for (int k = 0; k < 5; k++) begin
                u_iosm_host_model.wr(sa(j, `IOSM_SM_TXF), 32'hc0de_0000 | (j << 4) | k);
            end
        end
        rc("fstat", `IOSM_FSTAT, 32'h000f_0f00);
        rc("flevel", `IOSM_FLEVEL, 32'h0404_0404);
        rc("fifo_debug_flags", `IOSM_FIFO_DEBUG_FLAGS, 32'h000f_0f00);
        rc("fifo_debug_flags", `IOSM_FIFO_DEBUG_FLAGS, 32'h000f_0f00);
        u_iosm_host_model.wr(`IOSM_FIFO_DEBUG_FLAGS, 32'h000f_0f00);
        rc("fifo_debug_flags", `IOSM_FIFO_DEBUG_FLAGS, 32'h0);
        u_iosm_host_model.wr(`IOSM_CTRL, 32'h8);
        repeat (40) @(posedge clk);
        chk("pins", pins_out, 32'hc0de_0033);
        rc("flevel", `IOSM_FLEVEL, 32'h4004_0404);
    endtask

    // main sequence
    initial begin
        @(negedge reset);
        t_reset();
        t_forced();
        t_restart();
        t_stream();
        t_underflow();
        t_overflow();
        tally_and_finish();
    end
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule // iosm_top_tb
